// ---- common/e3te_pkg.sv ----
// Purpose: Shared constants and types for the E3 transmit overhead and
//          framing error insertion block.
// Assumes: AXI4-Lite register access, one payload bit per valid beat.
// Notes:   Register offsets are kept as indices; byte address is index * 4.

package e3te_pkg;

   // ==========================================================
   // Register map
   localparam int AXI_AW = 12;
   localparam int AXI_DW = 32;
   localparam int REG_W = 16;
   localparam logic [AXI_AW-1:0] IDX_CTRL = 12'h118;
   localparam logic [AXI_AW-1:0] IDX_ERR = 12'h11a;
   localparam logic [AXI_AW-1:0] IDX_RSV0 = 12'h11c;
   localparam logic [AXI_AW-1:0] IDX_RSV1 = 12'h11e;
   localparam logic [AXI_AW-1:0] ADDR_CTRL = IDX_CTRL << 2;
   localparam logic [AXI_AW-1:0] ADDR_ERR = IDX_ERR << 2;
   localparam logic [AXI_AW-1:0] ADDR_RSV0 = IDX_RSV0 << 2;
   localparam logic [AXI_AW-1:0] ADDR_RSV1 = IDX_RSV1 << 2;
   localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
   localparam logic [REG_W-1:0] CTRL_MASK = 16'h030f;
   localparam logic [REG_W-1:0] ERR_MASK = 16'h001f;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Field positions
   localparam int CTRL_AIS_BIT = 0;
   localparam int CTRL_FGD_BIT = 1;
   localparam int CTRL_ASEL_LSB = 2;
   localparam int CTRL_NSEL_LSB = 8;
   localparam int ERR_TRIG_BIT = 0;
   localparam int ERR_SW_BIT = 1;
   localparam int ERR_EN_BIT = 2;
   localparam int ERR_TYPE_LSB = 3;

   // ==========================================================
   // Frame layout
   localparam int POS_W = 11;
   localparam logic [POS_W-1:0] FRAME_LAST = 11'h5ff;
   localparam logic [POS_W-1:0] FAS_LEN = 11'h00a;
   localparam logic [POS_W-1:0] FAS_LAST = 11'h009;
   localparam logic [POS_W-1:0] A_POS = 11'h00a;
   localparam logic [POS_W-1:0] N_POS = 11'h00b;
   localparam logic [9:0] FAS_WORD = 10'h3d0;
   localparam logic [2:0] ERR_FRAMES_ONE = 3'h1;
   localparam logic [2:0] ERR_FRAMES_FOUR = 3'h4;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      NSRC_ONE = 2'b00, NSRC_HDLC = 2'b01, NSRC_FEAC = 2'b10, NSRC_ZERO = 2'b11
   } e3te_nsrc_t;
   typedef enum logic [1:0] {
      ASRC_AUTO = 2'b00, ASRC_FEAC = 2'b01, ASRC_ZERO = 2'b10, ASRC_ONE = 2'b11
   } e3te_asrc_t;
   typedef enum logic [1:0] {
      FERR_BIT1 = 2'b00, FERR_WORD1 = 2'b01, FERR_BIT4 = 2'b10,
      FERR_WORD4 = 2'b11
   } e3te_ferr_t;
   typedef enum logic [1:0] {
      SEL_CTRL = 2'b00, SEL_ERR = 2'b01, SEL_RSV = 2'b10, SEL_NONE = 2'b11
   } e3te_sel_t;

   typedef struct packed {
      e3te_nsrc_t n_bit_source_sel;
      e3te_asrc_t a_bit_source_sel;
      logic frame_gen_disable;
      logic force_all_ones;
   } e3te_ctrl_t;

   typedef struct packed {
      e3te_ferr_t frame_err_type;
      logic frame_err_insert_en;
      logic sw_single_err;
      logic err_trigger_sel;
   } e3te_errcfg_t;

   typedef struct packed {
      logic los;
      logic oof;
      logic ais;
      logic lof;
      logic lof_en;
      logic los_dis;
      logic oof_dis;
      logic ais_dis;
   } e3te_alarm_t;

   typedef struct packed {
      logic valid;
      logic data;
   } e3te_bit_t;

endpackage

// ---- hw/e3te_err_ctl.sv ----
// Purpose: Framing error trigger, arming and frame counting.
// Assumes: ext_trig already synchronised to aclk.
// Notes:   One pending request at a time; extra edges merge into it.
`timescale 1ns/100ps
`default_nettype none

module e3te_err_ctl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire e3te_pkg::e3te_errcfg_t cfg,
   input wire logic ext_trig,
   input wire logic frame_start,
   input wire logic fas_end,
   output logic err_now,
   output logic word_err
);
   import e3te_pkg::*;

   typedef enum logic [1:0] {
      ERR_IDLE = 2'b00, ERR_ARMED = 2'b01, ERR_ACTIVE = 2'b10
   } e3te_est_t;

   e3te_est_t state_q, state_d;
   logic trig_q, trig_d, pend_q, pend_d, word_q, word_d, trig, rise;
   logic [2:0] left_q, left_d;

   // ==========================================================
   // Trigger source and edge
   // Mode change may itself look like an edge; software avoids it [R12]
   assign trig = cfg.err_trigger_sel ? ext_trig : cfg.sw_single_err; // [R11]
   assign rise = trig & ~trig_q & cfg.frame_err_insert_en; // [R9] [R8]
   assign err_now = cfg.frame_err_insert_en &&
                    (state_q == ERR_ACTIVE ||
                     (state_q == ERR_ARMED && frame_start)); // [R15] [R8]
   assign word_err = (state_q == ERR_ACTIVE) ? word_q
                                             : cfg.frame_err_type[0];

   always_comb begin
      state_d = state_q;
      pend_d = pend_q;
      word_d = word_q;
      left_d = left_q;
      trig_d = trig;
      unique case (state_q)
         ERR_IDLE: begin
            if (rise) state_d = ERR_ARMED;
         end
         ERR_ARMED: begin
            // Several edges before the FAS collapse to one error [R10]
            if (!cfg.frame_err_insert_en) begin
               state_d = ERR_IDLE; // [R8]
            end else if (frame_start) begin
               state_d = ERR_ACTIVE;
               word_d = cfg.frame_err_type[0]; // [R7]
               left_d = cfg.frame_err_type[1] ? ERR_FRAMES_FOUR
                                              : ERR_FRAMES_ONE; // [R7]
            end
         end
         ERR_ACTIVE: begin
            if (fas_end) left_d = left_q - 3'h1; // [R15]
            if (fas_end && left_q == ERR_FRAMES_ONE) begin
               // A new edge during the burst is kept, not lost
               state_d = (pend_q || rise) ? ERR_ARMED : ERR_IDLE;
               pend_d = 1'b0;
            end else if (rise) begin
               pend_d = 1'b1;
            end
         end
         default: state_d = ERR_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ERR_IDLE;
         pend_q <= 1'b0;
         word_q <= 1'b0;
         left_q <= 3'h0;
         trig_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pend_q <= pend_d;
         word_q <= word_d;
         left_q <= left_d;
         trig_q <= trig_d;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   no_err_off_a: assert property ( // [R8]
      (state_q == ERR_IDLE && !cfg.frame_err_insert_en) |=>
         state_q == ERR_IDLE)
      else $error("error armed while insertion disabled");
   edge_arms_a: assert property ( // [R9]
      (state_q == ERR_IDLE && rise) |=> state_q == ERR_ARMED)
      else $error("trigger edge did not arm an error");
   four_load_a: assert property ( // [R7]
      (state_q == ERR_ARMED && frame_start && cfg.frame_err_insert_en &&
       cfg.frame_err_type[1]) |=> left_q == ERR_FRAMES_FOUR)
      else $error("four frame burst not loaded");
   burst_cov: cover property (
      state_q == ERR_ACTIVE && fas_end && left_q == ERR_FRAMES_FOUR);
   merge_cov: cover property (
      state_q == ERR_ARMED && trig && !trig_q);

endmodule // e3te_err_ctl

`default_nettype wire

// ---- hw/e3te_tx_overhead.sv ----
// Purpose: E3 transmit overhead source selection, frame generation,
//          all-ones alarm and framing error insertion, AXI4-Lite regs.
// Assumes: One payload bit per tx_in.valid; receive alarms on aclk.
// Notes:   Frame position free-runs from reset; bit 0 is the first FAS bit.
//
// Behaviour
// R1: N bit: 00 one, 01 HDLC, 10 FEAC, 11 zero.
// R2: A bit: 00 auto alarms, 01 FEAC, 10 zero, 11 one.
// R3: N and A both on FEAC carry the same stream, one bit per frame.
// R4: Frame generation disabled passes incoming overhead positions through.
// R5: Passed overhead still overwritten by error insertion and all ones.
// R6: Alarm bit forces the whole outgoing stream to ones.
// R7: Error type: bit or word, in one or four frames.
// R8: No framing errors while insertion enable is zero.
// R9: Each rising edge of the software bit gives exactly one error.
// R10: Several toggles between opportunities still give only one error.
// R11: Trigger select picks software bit at 0, external input at 1.
// R12: Software keeps trigger select still while either trigger is high.
// R13: Control and error registers only; two reserved offsets read zero.
// R14: Auto A bit is one on enabled LOS, OOF, AIS or LOF.
// R15: Requested error lands on the next FAS; four-frame modes span four.
// R16: All register bits reset to zero; reserved bits read zero.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module e3te_tx_overhead (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [e3te_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [e3te_pkg::AXI_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [e3te_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [e3te_pkg::AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire e3te_pkg::e3te_bit_t tx_in,
   input wire logic hdlc_bit,
   input wire logic feac_bit,
   input wire e3te_pkg::e3te_alarm_t rx_alarm,
   input wire logic ext_err_insert_in,
   output e3te_pkg::e3te_bit_t tx_out,
   output logic tx_overhead
);
   import e3te_pkg::*;

   // ==========================================================
   // Helpers
   function automatic e3te_sel_t decode(input logic [AXI_AW-1:0] a);
      logic [AXI_AW-1:0] w;
      w = {a[AXI_AW-1:2], 2'b00};
      if (w == ADDR_CTRL) decode = SEL_CTRL;
      else if (w == ADDR_ERR) decode = SEL_ERR;
      else if (w == ADDR_RSV0 || w == ADDR_RSV1) decode = SEL_RSV;
      else decode = SEL_NONE;
   endfunction

   function automatic logic [REG_W-1:0] merge(
      input logic [REG_W-1:0] old,
      input logic [REG_W-1:0] nw,
      input logic [1:0] strb);
      logic [REG_W-1:0] r;
      r = old;
      for (int i = 0; i < 2; i++) begin
         if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      merge = r;
   endfunction

   // ==========================================================
   // Register file and AXI4-Lite slave
   logic [REG_W-1:0] ctrl_q, ctrl_d, err_q, err_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [AXI_DW-1:0] rdata_q, rdata_d;
   logic wr_go, rd_go;
   e3te_sel_t wsel, rsel;
   e3te_ctrl_t ctrl;
   e3te_errcfg_t ecfg;

   // Both channels taken together keeps the write path one cycle long
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   assign rd_go = s_axi_arvalid && !rvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign wsel = decode(s_axi_awaddr);
   assign rsel = decode(s_axi_araddr);

   assign ctrl.n_bit_source_sel = e3te_nsrc_t'(ctrl_q[CTRL_NSEL_LSB +: 2]);
   assign ctrl.a_bit_source_sel = e3te_asrc_t'(ctrl_q[CTRL_ASEL_LSB +: 2]);
   assign ctrl.frame_gen_disable = ctrl_q[CTRL_FGD_BIT];
   assign ctrl.force_all_ones = ctrl_q[CTRL_AIS_BIT];
   assign ecfg.frame_err_type = e3te_ferr_t'(err_q[ERR_TYPE_LSB +: 2]);
   assign ecfg.frame_err_insert_en = err_q[ERR_EN_BIT];
   assign ecfg.sw_single_err = err_q[ERR_SW_BIT];
   assign ecfg.err_trigger_sel = err_q[ERR_TRIG_BIT];

   always_comb begin
      ctrl_d = ctrl_q;
      err_d = err_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (wr_go) begin
         bvalid_d = 1'b1;
         bresp_d = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         // Reserved bits are masked so they never store [R16]
         if (wsel == SEL_CTRL) begin
            ctrl_d = merge(ctrl_q, s_axi_wdata[REG_W-1:0],
                           s_axi_wstrb[1:0]) & CTRL_MASK; // [R13]
         end
         if (wsel == SEL_ERR) begin
            err_d = merge(err_q, s_axi_wdata[REG_W-1:0],
                          s_axi_wstrb[1:0]) & ERR_MASK; // [R13]
         end
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   always_comb begin
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         unique case (rsel)
            SEL_CTRL: rdata_d = AXI_DW'(ctrl_q);
            SEL_ERR: rdata_d = AXI_DW'(err_q);
            SEL_RSV: rdata_d = '0; // [R13]
            SEL_NONE: rdata_d = '0;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= REG_RESET; // [R16]
         err_q <= REG_RESET; // [R16]
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         err_q <= err_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // External trigger synchroniser
   logic ext_s1_q, ext_s2_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
      end else begin
         ext_s1_q <= ext_err_insert_in;
         ext_s2_q <= ext_s1_q;
      end
   end

   // ==========================================================
   // Frame position
   logic [POS_W-1:0] pos_q, pos_d;
   logic frame_start, fas_end, in_fas;

   assign frame_start = tx_in.valid && (pos_q == '0);
   assign fas_end = tx_in.valid && (pos_q == FAS_LAST);
   assign in_fas = pos_q < FAS_LEN;

   always_comb begin
      pos_d = pos_q;
      if (tx_in.valid) pos_d = (pos_q == FRAME_LAST) ? '0 : pos_q + 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) pos_q <= '0;
      else pos_q <= pos_d;
   end

   // ==========================================================
   // Error control
   logic err_now, word_err;

   e3te_err_ctl u_err (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(ecfg),
      .ext_trig(ext_s2_q),
      .frame_start(frame_start),
      .fas_end(fas_end),
      .err_now(err_now),
      .word_err(word_err)
   );

   // ==========================================================
   // Overhead sources
   logic n_bit, a_bit, auto_a;

   assign auto_a = (rx_alarm.los && !rx_alarm.los_dis) ||
                   (rx_alarm.oof && !rx_alarm.oof_dis) ||
                   (rx_alarm.ais && !rx_alarm.ais_dis) ||
                   (rx_alarm.lof && rx_alarm.lof_en); // [R14]

   always_comb begin
      unique case (ctrl.n_bit_source_sel) // [R1]
         NSRC_ONE: n_bit = 1'b1;
         NSRC_HDLC: n_bit = hdlc_bit;
         NSRC_FEAC: n_bit = feac_bit; // [R3]
         NSRC_ZERO: n_bit = 1'b0;
      endcase
   end

   always_comb begin
      unique case (ctrl.a_bit_source_sel) // [R2]
         ASRC_AUTO: a_bit = auto_a;
         ASRC_FEAC: a_bit = feac_bit; // [R3]
         ASRC_ZERO: a_bit = 1'b0;
         ASRC_ONE: a_bit = 1'b1;
      endcase
   end

   // ==========================================================
   // Output bit
   e3te_bit_t out_q, out_d;
   logic oh_q, oh_d, bit_v;

   always_comb begin
      bit_v = tx_in.data;
      oh_d = 1'b0;
      if (in_fas) begin
         bit_v = FAS_WORD[4'(FAS_LAST - pos_q)];
         oh_d = 1'b1;
      end else if (pos_q == A_POS) begin
         bit_v = a_bit;
         oh_d = 1'b1;
      end else if (pos_q == N_POS) begin
         bit_v = n_bit;
         oh_d = 1'b1;
      end
      if (oh_d && ctrl.frame_gen_disable) bit_v = tx_in.data; // [R4]
      // Bit errors hit the first FAS bit; word errors all ten [R7] [R5]
      if (err_now && in_fas && (word_err || pos_q == '0)) begin
         bit_v = ~bit_v; // [R15]
      end
      if (ctrl.force_all_ones) bit_v = 1'b1; // [R6] [R5]
      out_d.valid = tx_in.valid;
      out_d.data = tx_in.valid ? bit_v : out_q.data;
      if (!tx_in.valid) oh_d = oh_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_q <= '0;
         oh_q <= 1'b0;
      end else begin
         out_q <= out_d;
         oh_q <= oh_d;
      end
   end

   assign tx_out = out_q;
   assign tx_overhead = oh_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic plain;
   assign plain = tx_in.valid && !ctrl.force_all_ones &&
                  !ctrl.frame_gen_disable;

   all_ones_a: assert property ( // [R6]
      (tx_in.valid && ctrl.force_all_ones) |=> tx_out.valid && tx_out.data)
      else $error("alarm did not force ones");
   n_fixed_a: assert property ( // [R1]
      (plain && pos_q == N_POS && ctrl.n_bit_source_sel inside
       {NSRC_ONE, NSRC_ZERO}) |=>
         tx_out.data == !$past(ctrl.n_bit_source_sel[0]))
      else $error("fixed N bit wrong");
   feac_both_a: assert property ( // [R3]
      (plain && ctrl.n_bit_source_sel == NSRC_FEAC &&
       ctrl.a_bit_source_sel == ASRC_FEAC && pos_q == A_POS) |=>
         tx_out.data == $past(feac_bit) ##1 1'b1)
      else $error("FEAC A bit wrong");
   auto_a_a: assert property ( // [R14]
      (plain && pos_q == A_POS && ctrl.a_bit_source_sel == ASRC_AUTO &&
       rx_alarm.los && !rx_alarm.los_dis) |=> tx_out.data)
      else $error("auto A bit missed LOS");
   pass_thru_a: assert property ( // [R4]
      (tx_in.valid && ctrl.frame_gen_disable && !ctrl.force_all_ones &&
       !err_now && pos_q <= N_POS) |=> tx_out.data == $past(tx_in.data))
      else $error("overhead not passed through");
   fas_error_a: assert property ( // [R15]
      (plain && err_now && pos_q == '0) |=>
         tx_out.data == !FAS_WORD[9] && tx_overhead)
      else $error("first FAS bit not corrupted");
   reset_zero_a: assert property ( // [R16]
      !$past(aresetn) |-> ctrl_q == REG_RESET && err_q == REG_RESET)
      else $error("registers not zero after reset");
   rsvd_read_a: assert property ( // [R13]
      (rd_go && rsel == SEL_RSV) |=>
         s_axi_rvalid && s_axi_rdata == '0 && s_axi_rresp == RESP_OKAY)
      else $error("reserved offset not read as zero");

   wr_cov: cover property (wr_go && wsel == SEL_ERR);
   word4_cov: cover property (
      err_now && ecfg.frame_err_type == FERR_WORD4 && pos_q == FAS_LAST);
   gen_off_cov: cover property (ctrl.frame_gen_disable && err_now);

endmodule // e3te_tx_overhead

`default_nettype wire

// ---- testbench/e3te_line_model.sv ----
// Purpose: Upstream payload source feeding the transmit overhead block.
// Assumes: One bit per valid beat; the block applies no backpressure.
// Notes:   Gaps are random; hold stops the stream during register updates.
`timescale 1ns/100ps
`default_nettype none

module e3te_line_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic hold,
   output var e3te_pkg::e3te_bit_t tx_in
);
   import e3te_pkg::*;
   integer seed = 44;
   logic [31:0] r;

   // ========
   // Bit source
   always @(posedge aclk) begin
      r = $random(seed);
      if (!aresetn) begin
         tx_in <= '0;
      end else begin
         // Data changes in gaps so stale bits never pass
         tx_in.valid <= !hold && (r[3:0] != 4'h0);
         tx_in.data <= r[4];
      end
   end
endmodule // e3te_line_model
`default_nettype wire

// ---- testbench/e3te_tx_overhead_tb.sv ----
// Purpose: Self-checking bench for the E3 transmit overhead block.
// Assumes: Stream is held still while a register write is in flight.
// Notes:   FAS flips weigh 1 at bit 0 and 16 at bits 1 to 9.
`timescale 1ns/100ps
`default_nettype none

module e3te_tx_overhead_tb;
   import e3te_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, hold = 1'b0;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic [AXI_DW-1:0] wdata = '0, rdata;
   logic [3:0] wstrb = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, tx_overhead;
   logic [1:0] bresp, rresp;
   logic hdlc_bit = 1'b0, feac_bit = 1'b0, ext_in = 1'b0, sel_s = 1'b0;
   e3te_alarm_t rx_alarm = '0;
   e3te_bit_t tx_in, tx_out;
   e3te_ctrl_t ctrl_s = '0;
   logic [POS_W-1:0] pos = '0, ppos = '0;
   logic pv = 1'b0, pd = 1'b0;
   int n_errors = 0, samples_checked = 0, flips = 0, frames = 0, cyc = 0;
   integer seed = 44;

   always #50 aclk = ~aclk;

   e3te_tx_overhead dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_in(tx_in),
      .hdlc_bit(hdlc_bit), .feac_bit(feac_bit), .rx_alarm(rx_alarm),
      .ext_err_insert_in(ext_in), .tx_out(tx_out),
      .tx_overhead(tx_overhead));
   e3te_line_model line (.aclk(aclk), .aresetn(aresetn), .hold(hold),
      .tx_in(tx_in));

   // ========
   // Checking
   task automatic tally_and_finish;
      $display("checked %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask

   function automatic logic exp_bit(input logic [POS_W-1:0] p,
         input logic din);
      logic a;
      logic [3:0] av;
      logic [3:0] nv;
      a = (rx_alarm.lof & rx_alarm.lof_en) | (rx_alarm.los & !rx_alarm.los_dis)
         | (rx_alarm.oof & !rx_alarm.oof_dis)
         | (rx_alarm.ais & !rx_alarm.ais_dis);
      av = {1'b1, 1'b0, feac_bit, a};
      nv = {1'b0, feac_bit, hdlc_bit, 1'b1};
      if (ctrl_s.force_all_ones)
         return 1'b1;
      if (ctrl_s.frame_gen_disable || p > N_POS)
         return din;
      if (p < FAS_LEN)
         return FAS_WORD[4'(FAS_LAST - p)];
      if (p == A_POS)
         return av[ctrl_s.a_bit_source_sel];
      return nv[ctrl_s.n_bit_source_sel];
   endfunction

   function automatic int exp_flips(input logic [1:0] t, input logic hit);
      return hit ? (t[0] ? 145 : 1) * (t[1] ? 4 : 1) : 0;
   endfunction

   always @(posedge aclk) begin
      hdlc_bit <= 1'($random(seed));
      feac_bit <= 1'($random(seed));
      rx_alarm <= e3te_alarm_t'(8'($random(seed)));
      cyc++;
      if (cyc == 95000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   // Output lags one clock cycle: check it, then predict
   always @(posedge aclk) begin
      if (!aresetn) begin
         pos = '0;
         pv = 1'b0;
      end else begin
         chk(32'(tx_out.valid), 32'(pv), "valid");
         if (pv && ppos < FAS_LEN && !ctrl_s.force_all_ones) begin
            chk(32'(tx_overhead), 32'h1, "mark");
            if (tx_out.data !== pd)
               flips += (ppos == '0) ? 1 : 16;
         end else if (pv)
            chk(32'({tx_overhead, tx_out.data}), 32'({ppos <= N_POS, pd}),
               "bit");
         pv = tx_in.valid;
         if (tx_in.valid) begin
            pd = exp_bit(pos, tx_in.data);
            ppos = pos;
            pos = (pos == FRAME_LAST) ? '0 : pos + 1'b1;
            if (pos == '0)
               frames++;
         end
      end
   end

   // ========
   // Bus and scenario tasks
   task automatic step;
      @(posedge aclk);
      #1;
   endtask

   task automatic wr(input logic [AXI_AW-1:0] a, input logic [15:0] d,
         input logic [3:0] s, input logic [1:0] er);
      logic [1:0] r;
      @(posedge aclk);
      hold <= 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      #1;
      while (!(awready && wready))
         step();
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      #1;
      while (!bvalid)
         step();
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
      hold <= 1'b0;
      chk(32'(r), 32'(er), "bresp");
   endtask

   task automatic rd(input logic [AXI_AW-1:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      #1;
      while (!arready)
         step();
      @(posedge aclk);
      arvalid <= 1'b0;
      rready <= 1'b1;
      #1;
      while (!rvalid)
         step();
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
      chk(d, ed, "rdata");
      chk(32'(r), 32'(er), "rresp");
   endtask

   task automatic setc(input e3te_ctrl_t c);
      wr(ADDR_CTRL, {6'h00, c.n_bit_source_sel, 4'h0, c.a_bit_source_sel,
         c.frame_gen_disable, c.force_all_ones}, 4'hf, RESP_OKAY);
      ctrl_s = c;
   endtask

   task automatic wait_frames(input int k);
      int f0;
      f0 = frames;
      while (frames < f0 + k || pos < 12)
         @(posedge aclk);
   endtask

   task automatic run_err(input e3te_ctrl_t c, input logic [1:0] t,
         input logic en, input logic sel, input logic [3:0] sws,
         input logic ext, input logic hit);
      setc(c);
      wr(ADDR_ERR, {11'h0, t, 2'b00, sel_s}, 4'hf, RESP_OKAY);
      // Arm well clear of the FAS so the target frame is known
      while (pos < 12 || pos > 1400)
         @(posedge aclk);
      flips = 0;
      for (int i = 3; i >= 0; i--)
         wr(ADDR_ERR, {11'h0, t, en, sws[i], sel}, 4'hf, RESP_OKAY);
      sel_s = sel;
      if (ext) begin
         ext_in <= 1'b1;
         repeat (3) @(posedge aclk);
         ext_in <= 1'b0;
      end
      wait_frames(4);
      chk(32'(flips), 32'(exp_flips(t, hit)), "flips");
      $display("error run done: type %0d sel %0d", t, sel);
   endtask

   initial begin
      e3te_ctrl_t c;
      logic [5:0] rv;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_CTRL, '0, RESP_OKAY);
      rd(ADDR_ERR, '0, RESP_OKAY);
      rd(ADDR_RSV0, '0, RESP_OKAY);
      rd(ADDR_RSV1, '0, RESP_OKAY);
      wr(12'h000, 16'hffff, 4'hf, RESP_SLVERR);
      rd(12'h000, '0, RESP_SLVERR);
      wr(ADDR_CTRL, 16'hffff, 4'hf, RESP_OKAY);
      ctrl_s = e3te_ctrl_t'(6'h3f);
      rd(ADDR_CTRL, 32'h0000030f, RESP_OKAY);
      wr(ADDR_CTRL, 16'h0000, 4'h2, RESP_OKAY);
      ctrl_s = e3te_ctrl_t'(6'h0f);
      rd(ADDR_CTRL, 32'h0000000f, RESP_OKAY);
      wr(ADDR_ERR, 16'hffe0, 4'hf, RESP_OKAY);
      rd(ADDR_ERR, '0, RESP_OKAY);
      $display("register test done");
      for (int i = 0; i < 4; i++) begin
         c = '0;
         c.n_bit_source_sel = e3te_nsrc_t'(2'(i));
         c.a_bit_source_sel = e3te_asrc_t'(2'(i + 3));
         setc(c);
         wait_frames(1);
      end
      $display("source select test done");
      for (int t = 0; t < 4; t++) begin
         rv = 6'($random(seed));
         c = e3te_ctrl_t'({rv[5:2], t == 3, 1'b0});
         run_err(c, 2'(t), 1'b1, 1'b0, 4'b0111, 1'b0, 1'b1);
      end
      run_err(ctrl_s, 2'd1, 1'b1, 1'b0, 4'b0101, 1'b0, 1'b1);
      run_err(ctrl_s, 2'd1, 1'b0, 1'b0, 4'b0111, 1'b0, 1'b0);
      run_err(ctrl_s, 2'd0, 1'b1, 1'b1, 4'b0111, 1'b0, 1'b0);
      run_err(ctrl_s, 2'd2, 1'b1, 1'b1, 4'b0000, 1'b1, 1'b1);
      run_err(ctrl_s, 2'd0, 1'b1, 1'b0, 4'b0000, 1'b1, 1'b0);
      c = ctrl_s;
      c.force_all_ones = 1'b1;
      run_err(c, 2'd3, 1'b1, 1'b0, 4'b0111, 1'b0, 1'b0);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      ctrl_s = '0;
      sel_s = 1'b0;
      rd(ADDR_CTRL, '0, RESP_OKAY);
      rd(ADDR_ERR, '0, RESP_OKAY);
      $display("second reset test done");
      tally_and_finish();
   end
endmodule // e3te_tx_overhead_tb
`default_nettype wire
